// file: hw/led_port_defs.svh
`ifndef LED_PORT_DEFS_SVH
`define LED_PORT_DEFS_SVH
`define REG_ENABLE_RUN 8'h00
`define REG_MODE_SEL 8'h01
`define REG_RATIO_HIGH 8'h02
`define REG_RATIO_LOW 8'h03
`define REG_SWITCH_HIGH 8'h04
`define REG_SWITCH_LOW 8'h05
`define REG_MISC_CONFIG 8'h36
`define MASK_ENABLE_RUN 8'h7F
`define MASK_MODE_SEL 8'h3F
`define MASK_HIGH_BYTE 8'h01
`define MASK_FULL_BYTE 8'hFF
`define MASK_MISC_CONFIG 8'h40
`define RST_ENABLE_RUN 8'h00
`define RST_MODE_SEL 8'h00
`define RST_RATIO_HIGH 8'h00
`define RST_RATIO_LOW 8'h00
`define RST_SWITCH_HIGH 8'h01
`define RST_SWITCH_LOW 8'hFF
`define RST_MISC_CONFIG 8'h00
`define POS_DEVICE_ENABLE 6
`define POS_SEQ_ONE 4
`define POS_SEQ_TWO 2
`define POS_SEQ_THREE 0
`define POS_STEP_ENABLE 6
`define SLAVE_ADDR_BASE 7'h32
`define STEP_HOLD_LOW 8'h16
`define STEP_HOLD_HIGH 8'h1E
`define BITS_PER_BYTE 4'h8
`define LAST_TX_BIT 4'h7
`endif

// file: hw/led_port_pkg.sv
package led_port_pkg;
	typedef enum logic [2:0] {
		ps_idle,
		ps_addr,
		ps_index,
		ps_wdata,
		ps_rdata,
		ps_skip
	} port_state_t;
	typedef struct packed {
		logic scl;
		logic sda;
	} line_state_t;
	typedef struct packed {
		logic [7:0] enable_and_engine_run;
		logic [7:0] engine_mode_select;
		logic [7:0] ratio_dim_enable_high;
		logic [7:0] ratio_dim_enable_low;
		logic [7:0] output_switch_high;
		logic [7:0] output_switch_low;
		logic [7:0] misc_config;
	} bank_state_t;
	typedef struct packed {
		port_state_t st;
		logic in_ack;
		logic [3:0] cnt;
		logic [7:0] shreg;
		logic rw;
		logic macked;
		logic [7:0] index;
		logic sda_oe;
		logic sda_level;
		logic [6:0] dev_addr;
	} port_core_t;
endpackage

// file: hw/line_monitor.sv
`timescale 1ns/1ps
module line_monitor (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_scl_rise,
	output logic o_scl_fall,
	output logic o_start,
	output logic o_stop
);
	import led_port_pkg::*;
	line_state_t prev;
	line_state_t next_prev;
	// Idle bus is high on both lines, so reset assumes high to avoid a false start.
	always_comb begin
		next_prev.scl = i_scl;
		next_prev.sda = i_sda;
	end
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			prev <= 2'b11;
		end else begin
			prev <= next_prev;
		end
	end
	assign o_scl_rise = i_scl && !prev.scl;
	assign o_scl_fall = !i_scl && prev.scl;
	assign o_start = i_scl && prev.scl && prev.sda && !i_sda;
	assign o_stop = i_scl && prev.scl && !prev.sda && i_sda;
endmodule

// file: hw/control_bank.sv
`timescale 1ns/1ps
`include "led_port_defs.svh"
module control_bank (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_we,
	input wire logic [7:0] i_waddr,
	input wire logic [7:0] i_wdata,
	input wire logic [7:0] i_raddr,
	output logic [7:0] o_rdata,
	output logic o_device_enable,
	output logic [1:0] o_sequencer_one_run_control,
	output logic [1:0] o_sequencer_two_run_control,
	output logic [1:0] o_sequencer_three_run_control,
	output logic [1:0] o_sequencer_one_operating_mode,
	output logic [1:0] o_sequencer_two_operating_mode,
	output logic [1:0] o_sequencer_three_operating_mode,
	output logic [8:0] o_output_ratiometric_enable,
	output logic [8:0] o_output_switch,
	output logic o_index_step_enable
);
	import led_port_pkg::*;
	bank_state_t bank;
	bank_state_t next_bank;
	// Reserved bits are masked on write, so they always read back as zero.
	always_comb begin
		next_bank = bank;
		if (i_we) begin
			case (i_waddr)
				`REG_ENABLE_RUN: next_bank.enable_and_engine_run = i_wdata & `MASK_ENABLE_RUN;
				`REG_MODE_SEL: next_bank.engine_mode_select = i_wdata & `MASK_MODE_SEL;
				`REG_RATIO_HIGH: next_bank.ratio_dim_enable_high = i_wdata & `MASK_HIGH_BYTE;
				`REG_RATIO_LOW: next_bank.ratio_dim_enable_low = i_wdata;
				`REG_SWITCH_HIGH: next_bank.output_switch_high = i_wdata & `MASK_HIGH_BYTE;
				`REG_SWITCH_LOW: next_bank.output_switch_low = i_wdata;
				`REG_MISC_CONFIG: next_bank.misc_config = i_wdata & `MASK_MISC_CONFIG;
				default: ;
			endcase
		end
	end
	always_comb begin
		case (i_raddr)
			`REG_ENABLE_RUN: o_rdata = bank.enable_and_engine_run;
			`REG_MODE_SEL: o_rdata = bank.engine_mode_select;
			`REG_RATIO_HIGH: o_rdata = bank.ratio_dim_enable_high;
			`REG_RATIO_LOW: o_rdata = bank.ratio_dim_enable_low;
			`REG_SWITCH_HIGH: o_rdata = bank.output_switch_high;
			`REG_SWITCH_LOW: o_rdata = bank.output_switch_low;
			`REG_MISC_CONFIG: o_rdata = bank.misc_config;
			default: o_rdata = 8'h00;
		endcase
	end
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			bank.enable_and_engine_run <= `RST_ENABLE_RUN;
			bank.engine_mode_select <= `RST_MODE_SEL;
			bank.ratio_dim_enable_high <= `RST_RATIO_HIGH;
			bank.ratio_dim_enable_low <= `RST_RATIO_LOW;
			bank.output_switch_high <= `RST_SWITCH_HIGH;
			bank.output_switch_low <= `RST_SWITCH_LOW;
			bank.misc_config <= `RST_MISC_CONFIG;
		end else begin
			bank <= next_bank;
		end
	end
	assign o_device_enable = bank.enable_and_engine_run[`POS_DEVICE_ENABLE];
	assign o_sequencer_one_run_control = bank.enable_and_engine_run[`POS_SEQ_ONE +: 2];
	assign o_sequencer_two_run_control = bank.enable_and_engine_run[`POS_SEQ_TWO +: 2];
	assign o_sequencer_three_run_control = bank.enable_and_engine_run[`POS_SEQ_THREE +: 2];
	assign o_sequencer_one_operating_mode = bank.engine_mode_select[`POS_SEQ_ONE +: 2];
	assign o_sequencer_two_operating_mode = bank.engine_mode_select[`POS_SEQ_TWO +: 2];
	assign o_sequencer_three_operating_mode = bank.engine_mode_select[`POS_SEQ_THREE +: 2];
	assign o_output_ratiometric_enable = {bank.ratio_dim_enable_high[0], bank.ratio_dim_enable_low};
	assign o_output_switch = {bank.output_switch_high[0], bank.output_switch_low};
	assign o_index_step_enable = bank.misc_config[`POS_STEP_ENABLE];
endmodule

// file: hw/led_serial_port.sv
`timescale 1ns/1ps
`include "led_port_defs.svh"
module led_serial_port (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_scl,
	input wire logic i_sda,
	input wire logic i_slave_addr_strap0,
	input wire logic i_slave_addr_strap1,
	output logic o_sda_out,
	output logic o_sda_oe,
	output logic o_device_enable,
	output logic [1:0] o_sequencer_one_run_control,
	output logic [1:0] o_sequencer_two_run_control,
	output logic [1:0] o_sequencer_three_run_control,
	output logic [1:0] o_sequencer_one_operating_mode,
	output logic [1:0] o_sequencer_two_operating_mode,
	output logic [1:0] o_sequencer_three_operating_mode,
	output logic [8:0] o_output_ratiometric_enable,
	output logic [8:0] o_output_switch,
	output logic o_index_step_enable
);
	import led_port_pkg::*;
	port_core_t core;
	port_core_t next_core;
	logic scl_rise;
	logic scl_fall;
	logic start_seen;
	logic stop_seen;
	logic bank_we;
	logic [7:0] bank_raddr;
	logic [7:0] bank_rdata;
	logic byte_done;
	logic addr_hit;
	logic in_hold;

	line_monitor u_line (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_scl(i_scl),
		.i_sda(i_sda),
		.o_scl_rise(scl_rise),
		.o_scl_fall(scl_fall),
		.o_start(start_seen),
		.o_stop(stop_seen)
	);

	control_bank u_bank (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_we(bank_we),
		.i_waddr(core.index),
		.i_wdata(core.shreg),
		.i_raddr(bank_raddr),
		.o_rdata(bank_rdata),
		.o_device_enable(o_device_enable),
		.o_sequencer_one_run_control(o_sequencer_one_run_control),
		.o_sequencer_two_run_control(o_sequencer_two_run_control),
		.o_sequencer_three_run_control(o_sequencer_three_run_control),
		.o_sequencer_one_operating_mode(o_sequencer_one_operating_mode),
		.o_sequencer_two_operating_mode(o_sequencer_two_operating_mode),
		.o_sequencer_three_operating_mode(o_sequencer_three_operating_mode),
		.o_output_ratiometric_enable(o_output_ratiometric_enable),
		.o_output_switch(o_output_switch),
		.o_index_step_enable(o_index_step_enable)
	);

	assign byte_done = !core.in_ack && core.cnt == `BITS_PER_BYTE;
	assign addr_hit = core.shreg[7:1] == core.dev_addr;
	assign in_hold = core.index >= `STEP_HOLD_LOW && core.index <= `STEP_HOLD_HIGH;
	// While reading, the byte after the current index is prepared so it can go out on the ack edge.
	assign bank_raddr = (core.st == ps_rdata) ? core.index + 8'h01 : core.index;

	always_comb begin
		next_core = core;
		bank_we = 1'b0;
		if (core.st == ps_idle) begin
			// Straps are only followed between transactions so the address never shifts mid-frame.
			next_core.dev_addr = `SLAVE_ADDR_BASE + {5'h00, i_slave_addr_strap1, i_slave_addr_strap0};
		end
		if (start_seen) begin
			next_core.st = ps_addr;
			next_core.in_ack = 1'b0;
			next_core.cnt = 4'h0;
			next_core.sda_oe = 1'b0;
		end else if (stop_seen) begin
			next_core.st = ps_idle;
			next_core.in_ack = 1'b0;
			next_core.cnt = 4'h0;
			next_core.sda_oe = 1'b0;
		end else begin
			case (core.st)
				ps_addr, ps_index, ps_wdata: begin
					if (scl_rise && !core.in_ack && core.cnt != `BITS_PER_BYTE) begin
						next_core.shreg = {core.shreg[6:0], i_sda};
						next_core.cnt = core.cnt + 4'h1;
					end
					if (scl_fall && byte_done) begin
						next_core.in_ack = 1'b1;
						next_core.cnt = 4'h0;
						next_core.sda_oe = 1'b1;
						case (core.st)
							ps_addr: begin
								if (!addr_hit) begin
									next_core.st = ps_skip;
									next_core.sda_oe = 1'b0;
									next_core.in_ack = 1'b0;
								end else begin
									next_core.rw = core.shreg[0];
								end
							end
							ps_index: next_core.index = core.shreg;
							ps_wdata: bank_we = 1'b1;
							default: ;
						endcase
					end else if (scl_fall && core.in_ack) begin
						next_core.in_ack = 1'b0;
						next_core.sda_oe = 1'b0;
						case (core.st)
							ps_addr: begin
								if (core.rw) begin
									next_core.st = ps_rdata;
									next_core.shreg = bank_rdata;
									next_core.sda_oe = !bank_rdata[7];
								end else begin
									next_core.st = ps_index;
								end
							end
							ps_index: next_core.st = ps_wdata;
							ps_wdata: begin
								if (o_index_step_enable && !in_hold) begin
									next_core.index = core.index + 8'h01;
								end
							end
							default: ;
						endcase
					end
				end
				ps_rdata: begin
					if (!core.in_ack) begin
						if (scl_fall) begin
							if (core.cnt == `LAST_TX_BIT) begin
								next_core.in_ack = 1'b1;
								next_core.sda_oe = 1'b0;
								next_core.cnt = 4'h0;
								next_core.macked = 1'b0;
							end else begin
								next_core.cnt = core.cnt + 4'h1;
								next_core.shreg = {core.shreg[6:0], 1'b0};
								next_core.sda_oe = !core.shreg[6];
							end
						end
					end else begin
						if (scl_rise) begin
							next_core.macked = !i_sda;
						end
						if (scl_fall) begin
							next_core.in_ack = 1'b0;
							if (core.macked) begin
								next_core.index = core.index + 8'h01;
								next_core.shreg = bank_rdata;
								next_core.sda_oe = !bank_rdata[7];
							end else begin
								next_core.st = ps_skip;
							end
						end
					end
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			core <= '0;
		end else begin
			core <= next_core;
		end
	end

	// The pin is only ever pulled low; the high level comes from the bus pull-up.
	assign o_sda_out = core.sda_level;
	assign o_sda_oe = core.sda_oe;

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_n);

	AST_ADDR_NACK: assert property (
		core.st == ps_addr && scl_fall && byte_done && !addr_hit && !start_seen && !stop_seen
		|=> !o_sda_oe && core.st == ps_skip)
		else $error("Foreign address was acknowledged.");

	AST_ADDR_ACK: assert property (
		core.st == ps_addr && scl_fall && byte_done && addr_hit && !start_seen && !stop_seen
		|=> o_sda_oe && core.in_ack)
		else $error("Own address not acknowledged.");

	AST_DIRECTION: assert property (
		core.st == ps_addr && scl_fall && byte_done && addr_hit && !start_seen && !stop_seen
		|=> core.rw == $past(core.shreg[0]))
		else $error("Direction bit not captured.");

	AST_WRITE_STROBE: assert property (
		bank_we |-> core.st == ps_wdata && byte_done && scl_fall)
		else $error("Register write outside a data byte.");

	AST_STEP_WRITE: assert property (
		core.st == ps_wdata && core.in_ack && scl_fall && o_index_step_enable && !in_hold
		&& !start_seen && !stop_seen
		|=> core.index == $past(core.index) + 8'h01)
		else $error("Index did not step after a write byte.");

	AST_HOLD_RANGE: assert property (
		core.st == ps_wdata && core.in_ack && scl_fall && in_hold
		|=> $stable(core.index))
		else $error("Index stepped inside the duty-cycle range.");

	AST_STEP_DISABLED: assert property (
		core.st == ps_wdata && !o_index_step_enable && !(core.st == ps_index)
		|=> core.index == $past(core.index) || $past(start_seen))
		else $error("Index stepped with stepping disabled.");

	AST_READ_STEP: assert property (
		core.st == ps_rdata && core.in_ack && scl_fall && core.macked && !start_seen && !stop_seen
		|=> core.index == $past(core.index) + 8'h01 && core.shreg == $past(bank_rdata))
		else $error("Read did not advance to the next register.");

	AST_READ_END: assert property (
		core.st == ps_rdata && core.in_ack && scl_fall && !core.macked && !start_seen && !stop_seen
		|=> !o_sda_oe [*2])
		else $error("Data line held after master refused a byte.");

	AST_STOP_RELEASE: assert property (
		stop_seen && !start_seen |=> core.st == ps_idle && !o_sda_oe)
		else $error("Stop did not release the port.");

	AST_ENABLE_WRITE: assert property (
		bank_we && core.index == `REG_ENABLE_RUN
		|=> o_device_enable == $past(core.shreg[`POS_DEVICE_ENABLE]))
		else $error("Device enable did not follow the write.");

	AST_SWITCH_WRITE: assert property (
		bank_we && core.index == `REG_SWITCH_LOW
		|=> o_output_switch[7:0] == $past(core.shreg))
		else $error("Output switch bits did not follow the write.");

	AST_INDEX_CAPTURE: assert property (
		core.st == ps_index && scl_fall && byte_done && !start_seen && !stop_seen
		|=> core.index == $past(core.shreg))
		else $error("Register index not captured.");

	// A read address hands straight over to the first data bit, so the release is checked against it.
	AST_ACK_RELEASE: assert property (
		core.st inside {ps_addr, ps_index, ps_wdata} && core.in_ack && scl_fall && !start_seen && !stop_seen
		|=> !core.in_ack && o_sda_oe == (core.st == ps_rdata && !core.shreg[7]))
		else $error("Acknowledge not released after the ninth clock.");

	AST_READ_BIT: assert property (
		core.st == ps_rdata && !core.in_ack && scl_fall && core.cnt != `LAST_TX_BIT && !start_seen && !stop_seen
		|=> o_sda_oe == !$past(core.shreg[6]))
		else $error("Read data bit not presented in order.");

	AST_READ_HANDOVER: assert property (
		core.st == ps_rdata && !core.in_ack && scl_fall && core.cnt == `LAST_TX_BIT && !start_seen && !stop_seen
		|=> !o_sda_oe && core.in_ack)
		else $error("Data line not released for the master acknowledge.");

	AST_SKIP_SILENT: assert property (
		core.st == ps_skip |-> !o_sda_oe)
		else $error("Data line driven while ignoring the bus.");

	AST_STRAP_HOLD: assert property (
		core.st != ps_idle |=> $stable(core.dev_addr))
		else $error("Own address changed inside a transfer.");

	AST_MODE_WRITE: assert property (
		bank_we && core.index == `REG_MODE_SEL
		|=> {o_sequencer_one_operating_mode, o_sequencer_two_operating_mode, o_sequencer_three_operating_mode} == $past(core.shreg[5:0]))
		else $error("Mode fields did not follow the write.");

	AST_RATIO_WRITE: assert property (
		bank_we && core.index == `REG_RATIO_LOW
		|=> o_output_ratiometric_enable[7:0] == $past(core.shreg))
		else $error("Ratiometric enables did not follow the write.");

	COV_WRITE_BYTE: cover property (bank_we);
	COV_STEPPED_WRITE: cover property (bank_we ##[1:1000] bank_we);
	COV_READ_ACKED: cover property (core.st == ps_rdata && core.in_ack && scl_fall && core.macked);
	COV_FOREIGN_ADDR: cover property (core.st == ps_addr ##1 core.st == ps_skip);
endmodule

// file: testbench/host_master_model.sv
`timescale 1ns/1ps
// Bus master on the far side. It releases data by driving 1, so the pull-up level wins.
module host_master_model (
	input wire logic i_clk,
	input wire logic i_sda,
	output logic o_scl,
	output logic o_sda
);
	initial begin
		o_scl = 1'b1;
		o_sda = 1'b1;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge i_clk);
		#2;
	endtask
	// Each clock phase spans several system clocks, so the device sees every level twice or more.
	task automatic bit_io(input logic b, output logic got);
		o_sda = b;
		tick(3);
		o_scl = 1'b1;
		tick(2);
		got = i_sda;
		tick(2);
		o_scl = 1'b0;
		tick(1);
	endtask
	task automatic start_c();
		o_sda = 1'b1;
		tick(2);
		o_scl = 1'b1;
		tick(3);
		o_sda = 1'b0;
		tick(3);
		o_scl = 1'b0;
		tick(1);
	endtask
	task automatic stop_c();
		o_sda = 1'b0;
		tick(2);
		o_scl = 1'b1;
		tick(3);
		o_sda = 1'b1;
		tick(3);
	endtask
	task automatic put_byte(input logic [7:0] b, output logic ack);
		logic g;
		for (int i = 7; i >= 0; i--) bit_io(b[i], g);
		bit_io(1'b1, ack);
	endtask
	task automatic get_byte(input logic give_ack, output logic [7:0] b);
		logic g;
		for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
		bit_io(~give_ack, g);
	endtask
endmodule

// file: testbench/led_serial_port_tb.sv
`timescale 1ns/1ps
module led_serial_port_tb;
	logic i_clk, i_rst_n, scl, m_sda, s0, s1, sda_out, sda_oe, dev_en, step_en;
	logic [1:0] run1, run2, run3, mode1, mode2, mode3;
	logic [8:0] ratio, sw;
	logic [6:0] dev_addr;
	logic [7:0] exp_reg [0:255];
	logic [7:0] wbuf [0:3];
	logic [7:0] addr_tab [0:8] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h36, 8'h10, 8'h80};
	logic [7:0] m_idx;
	wire sda_w;
	int failures, num_checks, cycles, n;
	integer seed = 32'ha1a72871;
	// Only a driven low reaches the wire; otherwise the pull-up holds it high.
	assign sda_w = m_sda & ~(sda_oe & ~sda_out);
	assign dev_addr = 7'h32 + {5'h00, s1, s0};
	always #12.5 i_clk = ~i_clk;
	host_master_model host (.i_clk(i_clk), .i_sda(sda_w), .o_scl(scl), .o_sda(m_sda));
	led_serial_port DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_scl(scl), .i_sda(sda_w),
		.i_slave_addr_strap0(s0), .i_slave_addr_strap1(s1), .o_sda_out(sda_out), .o_sda_oe(sda_oe),
		.o_device_enable(dev_en), .o_sequencer_one_run_control(run1), .o_sequencer_two_run_control(run2),
		.o_sequencer_three_run_control(run3), .o_sequencer_one_operating_mode(mode1),
		.o_sequencer_two_operating_mode(mode2), .o_sequencer_three_operating_mode(mode3),
		.o_output_ratiometric_enable(ratio), .o_output_switch(sw), .o_index_step_enable(step_en));
	function automatic logic [7:0] mask_of(input logic [7:0] a);
		case (a)
			8'h00: return 8'h7F;
			8'h01: return 8'h3F;
			8'h02, 8'h04: return 8'h01;
			8'h03, 8'h05: return 8'hFF;
			8'h36: return 8'h40;
			default: return 8'h00;
		endcase
	endfunction
	function automatic logic [31:0] exp_outs();
		return {exp_reg[0][6:0], exp_reg[1][5:0], exp_reg[2][0], exp_reg[3], exp_reg[4][0], exp_reg[5],
			exp_reg[8'h36][6]};
	endfunction
	task automatic end_of_test();
		if (failures == 0 && num_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic check_ack(input logic got, input logic want);
		num_checks++;
		if (got !== want) begin
			failures++;
			$display("BAD %0t ack %b expected %b", $time, got, want);
		end
	endtask
	task automatic check_byte(input logic [7:0] got, input logic [7:0] want);
		num_checks++;
		if (got !== want) begin
			failures++;
			$display("BAD %0t read %h expected %h", $time, got, want);
		end
	endtask
	task automatic check_outs();
		num_checks++;
		if ({dev_en, run1, run2, run3, mode1, mode2, mode3, ratio, sw, step_en} !== exp_outs()) begin
			failures++;
			$display("BAD %0t control outputs differ from model", $time);
		end
	endtask
	task automatic probe(input logic [6:0] ad, input logic want);
		logic a;
		host.start_c();
		host.put_byte({ad, 1'b0}, a);
		check_ack(a, want);
		host.stop_c();
	endtask
	task automatic wr(input logic [7:0] idx, input int cnt);
		logic a;
		host.start_c();
		host.put_byte({dev_addr, 1'b0}, a);
		check_ack(a, 1'b0);
		host.put_byte(idx, a);
		check_ack(a, 1'b0);
		m_idx = idx;
		for (int i = 0; i < cnt; i++) begin
			host.put_byte(wbuf[i], a);
			check_ack(a, 1'b0);
			exp_reg[m_idx] = wbuf[i] & mask_of(m_idx);
			if (exp_reg[8'h36][6] && !(m_idx >= 8'h16 && m_idx <= 8'h1E)) m_idx++;
		end
		host.stop_c();
		check_outs();
	endtask
	task automatic rd(input logic set_idx, input logic [7:0] idx, input int cnt);
		logic a;
		logic [7:0] b;
		if (set_idx) begin
			host.start_c();
			host.put_byte({dev_addr, 1'b0}, a);
			check_ack(a, 1'b0);
			host.put_byte(idx, a);
			check_ack(a, 1'b0);
			m_idx = idx;
		end
		host.start_c();
		host.put_byte({dev_addr, 1'b1}, a);
		check_ack(a, 1'b0);
		for (int i = 0; i < cnt; i++) begin
			host.get_byte(i != cnt - 1, b);
			check_byte(b, exp_reg[m_idx]);
			if (i != cnt - 1) m_idx++;
		end
		host.stop_c();
	endtask
	always @(posedge i_clk) begin
		cycles++;
		if (cycles == 40000) begin
			failures++;
			end_of_test();
		end
	end
	initial begin
		i_clk = 1'b0;
		i_rst_n = 1'b0;
		s0 = 1'b0;
		s1 = 1'b0;
		for (int i = 0; i < 256; i++) exp_reg[i] = 8'h00;
		exp_reg[4] = 8'h01;
		exp_reg[5] = 8'hFF;
		repeat (3) @(posedge i_clk);
		#2;
		i_rst_n = 1'b1;
		host.tick(3);
		check_outs();
		rd(1'b1, 8'h00, 6);
		rd(1'b1, 8'h36, 2);
		// Straps are changed only between transfers, where the design picks them up.
		for (int k = 0; k < 4; k++) begin
			{s1, s0} = 2'(k);
			host.tick(2);
			probe(7'h32 + 7'(k), 1'b0);
			probe(7'h32 + 7'((k + 1) % 4), 1'b1);
		end
		wbuf[0] = 8'hA5;
		wbuf[1] = 8'h5A;
		wr(8'h05, 2);
		rd(1'b1, 8'h04, 3);
		wbuf[0] = 8'hFF;
		wr(8'h36, 1);
		for (int i = 0; i < 4; i++) wbuf[i] = 8'($random(seed));
		wr(8'h00, 4);
		rd(1'b0, 8'h00, 1);
		wr(8'h1E, 2);
		rd(1'b0, 8'h00, 3);
		for (int t = 0; t < 24; t++) begin
			n = 1 + int'($unsigned($random(seed)) % 3);
			for (int i = 0; i < 4; i++) wbuf[i] = 8'($random(seed));
			wr(addr_tab[$unsigned($random(seed)) % 9], n);
			rd(1'b1, addr_tab[$unsigned($random(seed)) % 9], n + 1);
		end
		end_of_test();
	end
endmodule
